// ==== include/sfpe_pkg.sv ====
// Types shared by the flash sequencer, its checker and the testbench
package sfpe_pkg;
  typedef enum logic [2:0] {
    SFPE_JOB_NONE, SFPE_JOB_PAGE, SFPE_JOB_SECT, SFPE_JOB_B32, SFPE_JOB_B64, SFPE_JOB_CHIP
  } sfpe_job_t;
  typedef struct packed {
    logic [7:0] offset;
    logic [7:0] data;
  } sfpe_byte_t;
  typedef struct packed {
    sfpe_job_t job;
    logic [23:0] addr;
  } sfpe_op_t;
endpackage : sfpe_pkg

// ==== include/sfpe_regs.svh ====
// Command codes, timing figures and field positions of the flash sequencer
`ifndef SFPE_REGS_SVH
`define SFPE_REGS_SVH
`define SFPE_OP_WRITE_ENABLE_CMD 8'h06
`define SFPE_OP_WRDIS 8'h04
`define SFPE_OP_PP 8'h02
`define SFPE_OP_QPP 8'h32
`define SFPE_OP_FPP 8'hf2
`define SFPE_OP_SE 8'h20
`define SFPE_OP_BE32 8'h52
`define SFPE_OP_BE64 8'hd8
`define SFPE_OP_CE1 8'h60
`define SFPE_OP_CE2 8'hc7
`define SFPE_OP_DS 8'hb9
`define SFPE_OP_WAKE 8'hab
`define SFPE_PAGE_BYTES 256
`define SFPE_PP_US 600
`define SFPE_SE_US 1000
`define SFPE_BE_US 2000
`define SFPE_CE_US 5000
`define SFPE_DS_NS 3000
`define SFPE_RES_NS 3000
`define SFPE_CLK_NS 50
`define SFPE_QE_BIT 9
`endif

// ==== src/sfpe_fifo.sv ====
// Parameterised valid/ready FIFO
module sfpe_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  always_ff @(posedge clk_sys) begin
    if (clk_en && push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (clk_en) begin
      if (flush) begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count <= '0;
      end else begin
        if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
        if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
        count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end
endmodule : sfpe_fifo

// ==== src/sfpe_flash_seq.sv ====
// Serial flash program, erase and deep power-down command handler
`include "sfpe_regs.svh"
module sfpe_flash_seq #(
  parameter int PP_CYC = (`SFPE_PP_US * 1000) / `SFPE_CLK_NS,
  parameter int SE_CYC = (`SFPE_SE_US * 1000) / `SFPE_CLK_NS,
  parameter int BE_CYC = (`SFPE_BE_US * 1000) / `SFPE_CLK_NS,
  parameter int CE_CYC = (`SFPE_CE_US * 1000) / `SFPE_CLK_NS,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  // Serial pins
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic data_line_0,
  input wire logic data_line_1,
  input wire logic data_line_2,
  input wire logic data_line_3,
  // Status bits
  input wire logic [15:0] status_in,
  output logic busy_flag,
  output logic write_latch_flag,
  output logic deep_sleep,
  output logic standby,
  // Array write port
  output logic arr_valid,
  input wire logic arr_ready,
  output sfpe_pkg::sfpe_op_t arr_op,
  output logic [7:0] arr_data,
  output logic arr_last
);
  localparam int DS_CYC = (`SFPE_DS_NS + `SFPE_CLK_NS - 1) / `SFPE_CLK_NS;
  localparam int RES_CYC = (`SFPE_RES_NS + `SFPE_CLK_NS - 1) / `SFPE_CLK_NS;
  localparam int PAGE = `SFPE_PAGE_BYTES;

  typedef enum {
    SFPE_ST_IDLE, SFPE_ST_LOAD, SFPE_ST_RUN, SFPE_ST_DS_WAIT, SFPE_ST_SLEEP,
    SFPE_ST_WAKE
  } sfpe_state_t;
  sfpe_state_t state;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  logic [1:0] rst_sync;
  wire rst_int_n = rst_sync[1];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end

  wire [5:0] pin_raw = {sel_n, sclk, data_line_3, data_line_2, data_line_1, data_line_0};
  logic [5:0] pin_s1, pin_s2, pin_s3, pin_q;
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      pin_s1 <= 6'h20;
      pin_s2 <= 6'h20;
      pin_s3 <= 6'h20;
    end else if (clk_en) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  // Filtered copy follows only once the last two stages agree
  genvar gi;
  for (gi = 0; gi < 6; gi++) begin : g_pin
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) pin_q[gi] <= (gi == 5);
      else if (clk_en && (pin_s2[gi] == pin_s3[gi])) pin_q[gi] <= pin_s3[gi];
    end
  end
  logic sclk_d, sel_d;
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      sclk_d <= 1'b0;
      sel_d <= 1'b1;
    end else if (clk_en) begin
      sclk_d <= pin_q[4];
      sel_d <= pin_q[5];
    end
  end
  wire sel_low = !pin_q[5];
  wire sclk_rise = pin_q[4] && !sclk_d && sel_low;
  wire sel_fall = !pin_q[5] && sel_d;
  wire sel_rise = pin_q[5] && !sel_d;

  ////////////////////////////////////////////////////////////////////////////
  // Command shifter
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [5:0] phase; // 0 opcode, 1..3 address, 4 data
  logic [7:0] offs;
  logic byte_done;
  wire quad_data = (opcode == `SFPE_OP_QPP) && (phase == 6'd4);
  wire [7:0] next_shreg = quad_data ? {shreg[3:0], pin_q[3:0]} :
                                      {shreg[6:0], pin_q[0]};
  wire [2:0] step = quad_data ? 3'h4 : 3'h1;
  wire byte_end = sclk_rise && (bitcnt + step == 3'h0);
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      phase <= 6'h0;
      opcode <= 8'h00;
      addr <= 24'h0;
      byte_done <= 1'b0;
    end else if (clk_en) begin
      if (sel_fall) begin
        bitcnt <= 3'h0;
        phase <= 6'h0;
        byte_done <= 1'b0;
      end else if (sclk_rise) begin
        shreg <= next_shreg;
        bitcnt <= bitcnt + step;
        byte_done <= byte_end;
        if (byte_end) begin
          if (phase == 6'd0) opcode <= next_shreg;
          else if (phase < 6'd4) addr <= {addr[15:0], next_shreg};
          if (phase < 6'd4) phase <= phase + 6'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page data buffer with per-byte fill marks
  logic [7:0] page_mem [PAGE];
  logic [PAGE-1:0] filled;
  wire data_byte = byte_end && (phase == 6'd4);
  // Frames seen while busy or asleep must not touch a page being loaded
  always_ff @(posedge clk_sys) begin
    if (clk_en && data_byte && state == SFPE_ST_IDLE) page_mem[offs] <= next_shreg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode at select rise
  wire [4:0] bp = status_in[6:2];
  wire qe = status_in[`SFPE_QE_BIT];
  wire is_pp = (opcode == `SFPE_OP_PP) || (opcode == `SFPE_OP_FPP) ||
               ((opcode == `SFPE_OP_QPP) && qe);
  wire is_se = opcode == `SFPE_OP_SE;
  wire is_b32 = opcode == `SFPE_OP_BE32;
  wire is_b64 = opcode == `SFPE_OP_BE64;
  wire is_ce = (opcode == `SFPE_OP_CE1) || (opcode == `SFPE_OP_CE2);
  logic data_seen, addr_seen;
  wire whole = byte_done && (bitcnt == 3'h0);
  wire pp_ok = is_pp && whole && (phase == 6'd4) && (filled != '0);
  wire er_ok = (is_se || is_b32 || is_b64) && whole && (phase == 6'd4) &&
               (filled == '0) && !data_seen;
  wire op_ok = whole && (phase == 6'd1) && !addr_seen;
  // Protected region: top fraction of array selected by protect bits
  wire [4:0] prot_idx = bp;
  wire [4:0] reg_top = addr[23:19];
  wire protected_hit = (bp != 5'h0) && (reg_top >= (5'h1f - prot_idx));
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      data_seen <= 1'b0;
      addr_seen <= 1'b0;
    end else if (clk_en) begin
      if (sel_fall) begin
        data_seen <= 1'b0;
        addr_seen <= 1'b0;
      end else if (sclk_rise) begin
        if (phase == 6'd4) data_seen <= 1'b1;
        if (phase >= 6'd1) addr_seen <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  logic [31:0] timer;
  sfpe_pkg::sfpe_job_t job;
  logic [8:0] load_idx;
  logic fifo_in_ready, fifo_out_valid;
  sfpe_pkg::sfpe_byte_t fifo_out;
  wire in_sleep = (state == SFPE_ST_SLEEP);
  wire cycle_busy = (state == SFPE_ST_LOAD) || (state == SFPE_ST_RUN);
  wire [31:0] run_cyc = (job == sfpe_pkg::SFPE_JOB_PAGE) ? 32'(PP_CYC) :
                        (job == sfpe_pkg::SFPE_JOB_SECT) ? 32'(SE_CYC) :
                        (job == sfpe_pkg::SFPE_JOB_CHIP) ? 32'(CE_CYC) : 32'(BE_CYC);
  wire load_push = (state == SFPE_ST_LOAD) && filled[load_idx[7:0]] && !load_idx[8];
  wire start_ok = sel_rise && write_latch_flag && !protected_hit;

  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state <= SFPE_ST_IDLE;
      timer <= 32'h0;
      job <= sfpe_pkg::SFPE_JOB_NONE;
      load_idx <= 9'h0;
      write_latch_flag <= 1'b0;
      filled <= '0;
      offs <= 8'h00;
    end else if (clk_en) begin
      if (sel_fall) begin
        offs <= addr[7:0];
      end
      if (state == SFPE_ST_IDLE && sel_fall) filled <= '0;
      if (state == SFPE_ST_IDLE && data_byte) begin
        filled[offs] <= 1'b1;
        offs <= offs + 8'h01;
      end
      if (phase == 6'd3 && byte_end) offs <= next_shreg;
      case (state)
        SFPE_ST_IDLE: begin
          if (sel_rise && op_ok && opcode == `SFPE_OP_WRITE_ENABLE_CMD) write_latch_flag <= 1'b1;
          else if (sel_rise && op_ok && opcode == `SFPE_OP_WRDIS) write_latch_flag <= 1'b0;
          if (sel_rise && pp_ok && start_ok) begin
            job <= sfpe_pkg::SFPE_JOB_PAGE;
            load_idx <= 9'h0;
            state <= SFPE_ST_LOAD;
          end else if (sel_rise && er_ok && start_ok) begin
            job <= is_se ? sfpe_pkg::SFPE_JOB_SECT :
                   is_b32 ? sfpe_pkg::SFPE_JOB_B32 : sfpe_pkg::SFPE_JOB_B64;
            timer <= 32'h0;
            state <= SFPE_ST_RUN;
          end else if (sel_rise && is_ce && op_ok && write_latch_flag && bp == 5'h0) begin
            job <= sfpe_pkg::SFPE_JOB_CHIP;
            timer <= 32'h0;
            state <= SFPE_ST_RUN;
          end else if (sel_rise && op_ok && opcode == `SFPE_OP_DS) begin
            timer <= 32'h0;
            state <= SFPE_ST_DS_WAIT;
          end
        end
        SFPE_ST_LOAD: begin
          // Unfilled offsets are skipped, so those bytes of the page stay as they are
          if (load_push && fifo_in_ready || !filled[load_idx[7:0]] && !load_idx[8]) begin
            load_idx <= load_idx + 9'h1;
          end
          if (load_idx[8]) begin
            timer <= 32'h0;
            state <= SFPE_ST_RUN;
          end
        end
        SFPE_ST_RUN: begin
          // Deep sleep and other commands fall through ignored here
          timer <= timer + 32'h1;
          if (timer == run_cyc - 32'h2) write_latch_flag <= 1'b0;
          // Busy holds until the array has taken every request
          if (timer >= run_cyc - 32'h1 && !fifo_out_valid && !arr_valid) begin
            job <= sfpe_pkg::SFPE_JOB_NONE;
            state <= SFPE_ST_IDLE;
          end
        end
        SFPE_ST_DS_WAIT: begin
          timer <= timer + 32'h1;
          if (timer >= 32'(DS_CYC - 1)) state <= SFPE_ST_SLEEP;
        end
        SFPE_ST_SLEEP: begin
          if (sel_rise && op_ok && opcode == `SFPE_OP_WAKE) begin
            timer <= 32'h0;
            state <= SFPE_ST_WAKE;
          end
        end
        SFPE_ST_WAKE: begin
          timer <= timer + 32'h1;
          if (timer >= 32'(RES_CYC - 1)) state <= SFPE_ST_IDLE;
        end
        default: state <= SFPE_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page bytes stream to the array through the FIFO
  sfpe_pkg::sfpe_byte_t fifo_in;
  assign fifo_in = '{offset: load_idx[7:0], data: page_mem[load_idx[7:0]]};
  // One-cycle erase request; the output register is always empty then
  wire erase_go = (state == SFPE_ST_RUN) && (timer == 32'h0) &&
                  (job != sfpe_pkg::SFPE_JOB_PAGE);
  // Output register is free when empty or when its word is being taken
  wire out_free = !arr_valid || arr_ready;
  wire fifo_take = out_free && !erase_go;
  sfpe_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_int_n),
    .clk_en(clk_en),
    .flush(1'b0),
    .in_valid(load_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_take),
    .out_data(fifo_out)
  );

  // Registered array request; it stands until the array takes it
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      arr_valid <= 1'b0;
      arr_last <= 1'b0;
      arr_op <= '0;
      arr_data <= 8'h00;
    end else if (clk_en && (erase_go || out_free)) begin
      arr_valid <= erase_go || fifo_out_valid;
      arr_last <= erase_go;
      arr_op <= '{job: job, addr: erase_go ? addr : {addr[23:8], fifo_out.offset}};
      arr_data <= fifo_out.data;
    end
  end

  // Status outputs from flip-flops, one cycle behind the state
  always_ff @(posedge clk_sys or negedge rst_int_n) begin
    if (!rst_int_n) begin
      busy_flag <= 1'b0;
      deep_sleep <= 1'b0;
      standby <= 1'b0;
    end else if (clk_en) begin
      busy_flag <= cycle_busy;
      deep_sleep <= in_sleep;
      standby <= (state == SFPE_ST_IDLE) && pin_q[5];
    end
  end
endmodule : sfpe_flash_seq

// ==== verification/sfpe_flash_seq_checker.sv ====
// Port checks of the flash sequencer
module sfpe_flash_seq_checker #(
  parameter int PP_CYC = 50
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins and status
  input wire logic sel_n,
  input wire logic [15:0] status_in,
  input wire logic busy_flag,
  input wire logic write_latch_flag,
  input wire logic deep_sleep,
  input wire logic standby,
  // Array port
  input wire logic arr_valid,
  input wire logic arr_ready,
  input wire sfpe_pkg::sfpe_op_t arr_op,
  input wire logic [7:0] arr_data
);
  logic [31:0] busy_run;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // Length of the busy span so far
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) busy_run <= 32'h0;
    else busy_run <= busy_flag ? busy_run + 32'h1 : 32'h0;
  end
  chk_busy_after_sel: assert property ($rose(busy_flag) |-> sel_n)
    else $error("busy rose while selected");
  chk_busy_latched: assert property ($rose(busy_flag) |-> write_latch_flag)
    else $error("cycle began without latch");
  chk_latch_cleared: assert property ($fell(busy_flag) |-> !$past(write_latch_flag))
    else $error("latch still set at cycle end");
  chk_busy_length: assert property ($fell(busy_flag) |-> busy_run >= PP_CYC - 1)
    else $error("busy span too short");
  chk_sleep_idle: assert property (deep_sleep |-> !busy_flag)
    else $error("busy in deep sleep");
  chk_standby_state: assert property (standby |-> !busy_flag && !deep_sleep)
    else $error("standby while busy or asleep");
  chk_sleep_delay: assert property ($rose(deep_sleep) |-> $past(sel_n, 50))
    else $error("deep sleep entered too early");
  chk_arr_hold: assert property (arr_valid && !arr_ready |=>
    arr_valid && $stable(arr_data) && $stable(arr_op))
    else $error("array request dropped while stalled");
  chk_chip_unprot: assert property (
    arr_valid && arr_op.job == sfpe_pkg::SFPE_JOB_CHIP |-> status_in[6:2] == 5'h00)
    else $error("chip erase with protection set");
  cov_busy: cover property ($rose(busy_flag));
  cov_sleep: cover property ($rose(deep_sleep));
  cov_stall: cover property (arr_valid && !arr_ready);
endmodule : sfpe_flash_seq_checker

bind sfpe_flash_seq sfpe_flash_seq_checker #(.PP_CYC(PP_CYC)) i_sfpe_flash_seq_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .sel_n(sel_n), .status_in(status_in),
  .busy_flag(busy_flag), .write_latch_flag(write_latch_flag), .deep_sleep(deep_sleep),
  .standby(standby), .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_op(arr_op),
  .arr_data(arr_data));

// ==== verification/sfpe_host.sv ====
// Host serial controller model driving select, clock and data lines
module sfpe_host (
  // Clock
  input wire logic clk_sys,
  // Serial pins
  output logic sel_n,
  output logic sclk,
  output logic [3:0] dl
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    dl = 4'h0;
  end
  // Half of the 400 ns serial period
  task automatic half();
    repeat (4) @(posedge clk_sys);
  endtask : half
  // Bytes from index qf on go four bits an edge; cut drops trailing steps
  task automatic frame(input logic [7:0] b[$], input int qf, input int cut);
    int n;
    sel_n <= 1'b0;
    half();
    for (int i = 0; i < b.size(); i++) begin
      n = (i >= qf) ? 2 : 8;
      for (int k = n - 1; k >= 0; k--) begin
        if (i == b.size() - 1 && k < cut) break;
        sclk <= 1'b0;
        if (n == 2) dl <= b[i][k*4 +: 4];
        else dl <= {~dl[3:1], b[i][k]};
        half();
        sclk <= 1'b1;
        half();
      end
    end
    sclk <= 1'b0;
    half();
    sel_n <= 1'b1;
    dl <= ~dl;
    half();
    half();
  endtask : frame
endmodule : sfpe_host

// ==== verification/testbench.sv ====
// Self-checking bench of the flash sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] a;
    logic [15:0] st;
    logic wr;
    logic [3:0] cut;
    logic [23:0] m;
    sfpe_pkg::sfpe_job_t job;
  } sfpe_row_t;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] st = 16'h0000;
  logic arr_ready = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] cyc = 8'h00;
  logic sel_n, sclk, busy_flag, write_latch_flag, deep_sleep, standby, arr_valid, arr_last;
  logic [3:0] dl;
  logic [7:0] arr_data;
  sfpe_pkg::sfpe_op_t arr_op;
  sfpe_pkg::sfpe_op_t qo[$];
  logic [7:0] qd[$];
  logic ql[$];
  logic [7:0] pb[$];
  int miscompares = 0;
  int total_checks = 0;
  sfpe_row_t rows[11] = '{
    '{8'h20, 24'h012345, 16'h0000, 1'b1, 4'h0, 24'hfff000, sfpe_pkg::SFPE_JOB_SECT},
    '{8'h52, 24'h0a8001, 16'h0000, 1'b1, 4'h0, 24'hff8000, sfpe_pkg::SFPE_JOB_B32},
    '{8'hd8, 24'h3fffff, 16'h0000, 1'b1, 4'h0, 24'hff0000, sfpe_pkg::SFPE_JOB_B64},
    '{8'h60, 24'h000000, 16'h0000, 1'b1, 4'h0, 24'h000000, sfpe_pkg::SFPE_JOB_CHIP},
    '{8'hc7, 24'h000000, 16'h0000, 1'b1, 4'h0, 24'h000000, sfpe_pkg::SFPE_JOB_CHIP},
    '{8'h20, 24'h012345, 16'h0000, 1'b0, 4'h0, 24'h000000, sfpe_pkg::SFPE_JOB_NONE},
    '{8'h20, 24'hf81234, 16'h0004, 1'b1, 4'h0, 24'h000000, sfpe_pkg::SFPE_JOB_NONE},
    '{8'h52, 24'h001234, 16'h0004, 1'b1, 4'h0, 24'hff8000, sfpe_pkg::SFPE_JOB_B32},
    '{8'hc7, 24'h000000, 16'h0004, 1'b1, 4'h0, 24'h000000, sfpe_pkg::SFPE_JOB_NONE},
    '{8'h20, 24'h012345, 16'h0000, 1'b1, 4'h1, 24'h000000, sfpe_pkg::SFPE_JOB_NONE},
    '{8'h60, 24'h000000, 16'h0000, 1'b1, 4'h2, 24'h000000, sfpe_pkg::SFPE_JOB_NONE}};
  logic [7:0] sq[3] = '{8'h06, 8'hc7, 8'hb9};

  sfpe_host i_sfpe_host (.clk_sys(clk_sys), .sel_n(sel_n), .sclk(sclk), .dl(dl));
  sfpe_flash_seq #(.PP_CYC(40), .SE_CYC(60), .BE_CYC(80), .CE_CYC(300))
    i_sfpe_flash_seq (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .sel_n(sel_n),
    .sclk(sclk), .data_line_0(dl[0]), .data_line_1(dl[1]), .data_line_2(dl[2]),
    .data_line_3(dl[3]), .status_in(st), .busy_flag(busy_flag),
    .write_latch_flag(write_latch_flag), .deep_sleep(deep_sleep), .standby(standby),
    .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_op(arr_op), .arr_data(arr_data),
    .arr_last(arr_last));

  always #25 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////
  // Array side stalls 64 of every 128 cycles so the FIFO fills
  always @(posedge clk_sys) begin
    arr_ready <= cyc[6];
    cyc <= cyc + 8'h01;
    if (arr_valid === 1'b1 && arr_ready === 1'b1) begin
      qo.push_back(arr_op);
      qd.push_back(arr_data);
      ql.push_back(arr_last);
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  task automatic wait_idle();
    int idle;
    idle = 0;
    for (int k = 0; k < 20000 && idle < 300; k++) begin
      @(posedge clk_sys);
      idle = (busy_flag === 1'b0 && arr_valid === 1'b0) ? idle + 1 : 0;
    end
  endtask : wait_idle
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int na, input bit wr,
                     input int qf, input int cut);
    logic [7:0] fb[$];
    qo = {};
    qd = {};
    ql = {};
    fb = {8'h06};
    if (wr) i_sfpe_host.frame(fb, 999, 0);
    fb = {op};
    for (int k = na - 1; k >= 0; k--) fb.push_back(a[k*8 +: 8]);
    fb = {fb, pb};
    i_sfpe_host.frame(fb, qf, cut);
    wait_idle();
  endtask : cmd
  task automatic check_page(input logic [23:0] base);
    logic [8:0] em[256];
    int n;
    n = 0;
    foreach (em[j]) em[j] = 9'h000;
    foreach (pb[i]) em[8'(base[7:0] + i)] = {1'b1, pb[i]};
    foreach (em[j]) n += em[j][8];
    check(32'(qo.size()), 32'(n));
    foreach (qo[i]) begin
      check(32'(qo[i].job), 32'(sfpe_pkg::SFPE_JOB_PAGE));
      check(32'(qo[i].addr[23:8]), 32'(base[23:8]));
      check(32'({1'b1, qd[i]}), 32'(em[qo[i].addr[7:0]]));
    end
  endtask : check_page
  task automatic reset_and_check();
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    check(32'({busy_flag, write_latch_flag, deep_sleep, standby}), 32'h1);
  endtask : reset_and_check

  initial begin
    reset_and_check();
    foreach (rows[i]) begin
      st <= rows[i].st;
      pb = {};
      cmd(rows[i].op, rows[i].a, (rows[i].op inside {8'h60, 8'hc7}) ? 0 : 3, rows[i].wr, 999,
          rows[i].cut);
      check(32'(qo.size()), 32'(rows[i].job != sfpe_pkg::SFPE_JOB_NONE));
      if (qo.size() == 1) begin
        check(32'(qo[0].job), 32'(rows[i].job));
        check(32'(qo[0].addr & rows[i].m), 32'(rows[i].a & rows[i].m));
        check(32'(ql[0]), 32'h1);
      end
    end
    st <= 16'h0000;
    pb = {8'h11, 8'h22, 8'h33};
    cmd(8'h02, 24'h1230fe, 3, 1'b1, 999, 0);
    check_page(24'h1230fe);
    cmd(8'h32, 24'h000100, 3, 1'b1, 4, 0);
    check(32'(qo.size()), 32'h0);
    st <= 16'h0200;
    pb = {};
    for (int i = 0; i < 258; i++) pb.push_back(8'(i) ^ ((i > 255) ? 8'hff : 8'h00));
    cmd(8'h32, 24'h000200, 3, 1'b1, 4, 0);
    check_page(24'h000200);
    st <= 16'h0000;
    pb = {8'h5a};
    cmd(8'hf2, 24'h000010, 3, 1'b1, 999, 3);
    check(32'(qo.size()), 32'h0);
    st <= 16'h0004;
    cmd(8'hf2, 24'hf80010, 3, 1'b1, 999, 0);
    check(32'(qo.size()), 32'h0);
    cmd(8'hf2, 24'h000010, 3, 1'b1, 999, 0);
    check_page(24'h000010);
    pb = {};
    cmd(8'hb9, 24'h000000, 0, 1'b0, 999, 0);
    check(32'({busy_flag, deep_sleep, standby}), 32'h2);
    cmd(8'h20, 24'h012345, 3, 1'b1, 999, 0);
    check(32'({qo.size(), write_latch_flag}), 32'h0);
    cmd(8'hab, 24'h000000, 0, 1'b0, 999, 0);
    check(32'({deep_sleep, standby}), 32'h1);
    st <= 16'h0000;
    qo = {};
    for (int i = 0; i < 3; i++) begin
      pb = {sq[i]};
      i_sfpe_host.frame(pb, 999, 0);
    end
    wait_idle();
    check(32'({qo.size(), deep_sleep}), 32'h2);
    // Write enable sent while the clock enable is low must leave no trace
    clk_en <= 1'b0;
    pb = {8'h06};
    i_sfpe_host.frame(pb, 999, 0);
    clk_en <= 1'b1;
    repeat (20) @(posedge clk_sys);
    check(32'(write_latch_flag), 32'h0);
    pb = {};
    cmd(8'hb9, 24'h000000, 0, 1'b0, 999, 0);
    reset_and_check();
    print_verdict();
  end
  initial begin
    #4000000;
    miscompares++;
    print_verdict();
  end
endmodule : testbench
